// *** src/cxu_pkg.sv ***
// constants and types for the subtract, shift and pointer execution unit
// Contract
// - set_carry_op opcode DF forces carry high, other flags kept, 4 cycles
// - arithmetic shift D0/D1 moves bits down, bit 7 kept and copied to bit 6
// - shift: carry gets old bit 0, zero/sign from result, overflow cleared
// - pointer op 31: bits 1:0 = 10 or 01 load bits 7:3 of one pointer
// - bits 1:0 = 00 load bits 7:4 of both, pointer zero bit3=0, one bit3=1
// - pointers live at register addresses D6 and D7
// - stop op 7F halts core and clock, all registers keep contents; bus writes to flags and pointers still land while stopped
// - stop left on external reset or external interrupt
// - subtract writes destination minus source, source untouched
// - subtract adds two's complement; opcodes 22 to 26 with their cycle counts
// - subtract: carry on borrow, zero and sign from result
// - overflow when operand signs differ and result sign equals source sign
// - subtract sets decimal flag, half-carry set on nibble borrow
// - subtract_borrow_op subtracts source and carry from destination
// - subtract_borrow_op opcodes 32 to 36, same forms and counts as subtract
// - subtract_borrow_op flags as subtract, borrow includes incoming carry
package cxu_pkg;
    // ----------------------------------------
    // opcodes
    // ----------------------------------------
    localparam logic [7:0] OP_SET_CARRY = 8'hDF;
    localparam logic [7:0] OP_SHR_DIR = 8'hD0;
    localparam logic [7:0] OP_SHR_IND = 8'hD1;
    localparam logic [7:0] OP_LOAD_PTR = 8'h31;
    localparam logic [7:0] OP_STOP = 8'h7F;
    localparam logic [7:0] OP_SUB_BASE = 8'h22;
    localparam logic [7:0] OP_SBC_BASE = 8'h32;
    localparam logic [7:0] OP_SUB_RIR = 8'h23;
    localparam logic [7:0] OP_SBC_RIR = 8'h33;
    localparam logic [7:0] OP_FORM_LAST = 8'h04;
    // ----------------------------------------
    // cycle counts
    // ----------------------------------------
    localparam logic [2:0] CYC_SHORT = 3'h4;
    localparam logic [2:0] CYC_LONG = 3'h6;
    // ----------------------------------------
    // register map and reset values
    // ----------------------------------------
    localparam logic [7:0] ADDR_FLAGS = 8'hD5;
    localparam logic [7:0] ADDR_PTR0 = 8'hD6;
    localparam logic [7:0] ADDR_PTR1 = 8'hD7;
    localparam logic [7:0] ADDR_STATUS = 8'hD8;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_PTR0 = 8'hC0;
    localparam logic [7:0] RST_PTR1 = 8'hC8;
    // ----------------------------------------
    // flag positions and interrupt synchronizer length
    // ----------------------------------------
    localparam int FL_C = 7;
    localparam int FL_Z = 6;
    localparam int FL_S = 5;
    localparam int FL_V = 4;
    localparam int FL_D = 3;
    localparam int FL_H = 2;
    localparam int SYNC_LEN = 3;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] dst;
        logic [7:0] src;
    } cxu_instr_t;
    typedef struct packed {
        logic [7:0] value;
        logic write;
    } cxu_result_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_STOP = 2'b10
    } cxu_state_t;
endpackage

// *** src/cxu_exec.sv ***
// execution unit for subtract, shift, set-carry, pointer load and stop
`timescale 1ns/1ps
module cxu_exec
    import cxu_pkg::*;
(
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic INSTR_VALID_I,
    input wire cxu_instr_t INSTR_I,
    input wire logic EXT_INT_I,
    input wire logic [7:0] BUS_ADDR_I,
    input wire logic [7:0] BUS_WDATA_I,
    input wire logic BUS_WR_I,
    input wire logic BUS_RD_I,
    output logic [7:0] BUS_RDATA_O,
    output logic READY_O,
    output logic DONE_O,
    output cxu_result_t RESULT_O,
    output logic [7:0] FLAGS_O,
    output logic CLK_STOP_O
);
    // ----------------------------------------
    // subtract core, shared by both subtract groups
    // ----------------------------------------
    function automatic logic [13:0] sub_calc(input logic [7:0] d, input logic [7:0] s,
                                             input logic ci);
        logic [8:0] full;
        logic [4:0] low;
        logic [7:0] r;
        full = {1'b0, d} + {1'b0, ~s} + 9'h001 - {8'h00, ci};
        low = {1'b0, d[3:0]} - {1'b0, s[3:0]} - {4'h0, ci};
        r = full[7:0];
        // packs result, carry, zero, sign, overflow, decimal, half
        sub_calc = {r, ~full[8], (r == 8'h00), r[7],
                    (d[7] ^ s[7]) & (r[7] == s[7]),
                    1'b1, low[4]};
    endfunction

    function automatic logic [2:0] cycles_of(input logic [7:0] op);
        logic long_form;
        long_form = (op[3:0] > 4'h2) && (op[3:0] <= 4'h6);
        cycles_of = CYC_SHORT;
        if ((op[7:4] == 4'h2 || op[7:4] == 4'h3) && long_form)
        begin
            cycles_of = CYC_LONG;
        end
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    cxu_state_t state;
    cxu_state_t next_state;
    cxu_instr_t cur;
    logic [2:0] cnt;
    logic [7:0] flags;
    logic [7:0] ptr0;
    logic [7:0] ptr1;
    logic [SYNC_LEN-1:0] int_sync;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire logic [7:0] op_off_sub = cur.opcode - OP_SUB_BASE;
    wire logic [7:0] op_off_sbc = cur.opcode - OP_SBC_BASE;
    wire logic is_sub = op_off_sub <= OP_FORM_LAST;
    wire logic is_sbc = op_off_sbc <= OP_FORM_LAST;
    wire logic is_shr = (cur.opcode == OP_SHR_DIR) || (cur.opcode == OP_SHR_IND);
    wire logic is_scf = cur.opcode == OP_SET_CARRY;
    wire logic is_ptr = cur.opcode == OP_LOAD_PTR;
    wire logic is_stop = cur.opcode == OP_STOP;
    wire logic finish = (state == ST_EXEC) && (cnt == 3'h0);
    wire logic take = (state == ST_IDLE) && INSTR_VALID_I;
    // wake counts only once the second and third stages both hold a one
    wire logic wake = int_sync[1] & int_sync[2];

    // ----------------------------------------
    // datapath
    // ----------------------------------------
    wire logic carry_in = is_sbc & flags[FL_C];
    wire logic [13:0] sub_out = sub_calc(cur.dst, cur.src, carry_in);
    wire logic [7:0] shr_res = {cur.dst[7], cur.dst[7:1]};
    logic [7:0] next_flags;
    logic [7:0] next_value;
    logic next_write;

    always_comb
    begin
        next_flags = flags;
        next_value = 8'h00;
        next_write = 1'b0;
        if (is_sub || is_sbc)
        begin
            next_value = sub_out[13:6];
            next_write = 1'b1;
            next_flags[FL_C] = sub_out[5];
            next_flags[FL_Z] = sub_out[4];
            next_flags[FL_S] = sub_out[3];
            next_flags[FL_V] = sub_out[2];
            next_flags[FL_D] = sub_out[1];
            next_flags[FL_H] = sub_out[0];
        end
        else if (is_shr)
        begin
            next_value = shr_res;
            next_write = 1'b1;
            next_flags[FL_C] = cur.dst[0];
            next_flags[FL_Z] = (shr_res == 8'h00);
            next_flags[FL_S] = shr_res[7];
            next_flags[FL_V] = 1'b0;
        end
        else if (is_scf)
        begin
            next_flags[FL_C] = 1'b1;
        end
    end

    // pointer updates; 11 in the select bits writes nothing
    logic [7:0] next_ptr0;
    logic [7:0] next_ptr1;

    always_comb
    begin
        next_ptr0 = ptr0;
        next_ptr1 = ptr1;
        if (finish && is_ptr)
        begin
            unique case (cur.src[1:0])
                2'b10: next_ptr0[7:3] = cur.src[7:3];
                2'b01: next_ptr1[7:3] = cur.src[7:3];
                2'b00:
                begin
                    next_ptr0 = {cur.src[7:4], 4'h0 | {1'b0, ptr0[2:0]}};
                    next_ptr1 = {cur.src[7:4], 1'b1, ptr1[2:0]};
                end
                2'b11: next_ptr0 = ptr0;
            endcase
        end
        else if (BUS_WR_I && BUS_ADDR_I == ADDR_PTR0)
        begin
            next_ptr0 = BUS_WDATA_I;
        end
        else if (BUS_WR_I && BUS_ADDR_I == ADDR_PTR1)
        begin
            next_ptr1 = BUS_WDATA_I;
        end
    end

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE: if (take) next_state = ST_EXEC;
            ST_EXEC: if (finish) next_state = is_stop ? ST_STOP : ST_IDLE;
            ST_STOP: if (wake) next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            state <= ST_IDLE;
            cnt <= 3'h0;
            cur <= '0;
            int_sync <= '0;
        end
        else
        begin
            state <= next_state;
            int_sync <= {int_sync[SYNC_LEN-2:0], EXT_INT_I};
            if (take)
            begin
                cur <= INSTR_I;
                cnt <= cycles_of(INSTR_I.opcode) - 3'h1;
            end
            else if (state == ST_EXEC && cnt != 3'h0)
            begin
                cnt <= cnt - 3'h1;
            end
        end
    end

    // ----------------------------------------
    // architectural registers and outputs
    // ----------------------------------------
    // instruction completion wins over a bus write to the same register
    wire logic bus_flags_wr = BUS_WR_I && BUS_ADDR_I == ADDR_FLAGS;

    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            flags <= RST_FLAGS;
            ptr0 <= RST_PTR0;
            ptr1 <= RST_PTR1;
            RESULT_O <= '0;
            DONE_O <= 1'b0;
            READY_O <= 1'b0;
            CLK_STOP_O <= 1'b0;
            FLAGS_O <= RST_FLAGS;
        end
        else
        begin
            ptr0 <= next_ptr0;
            ptr1 <= next_ptr1;
            DONE_O <= finish;
            READY_O <= (next_state == ST_IDLE);
            CLK_STOP_O <= (next_state == ST_STOP);
            if (finish)
            begin
                flags <= next_flags;
                FLAGS_O <= next_flags;
                RESULT_O <= '{value: next_value, write: next_write};
            end
            else
            begin
                RESULT_O.write <= 1'b0;
                if (bus_flags_wr)
                begin
                    flags <= BUS_WDATA_I;
                    FLAGS_O <= BUS_WDATA_I;
                end
            end
        end
    end

    // ----------------------------------------
    // register port read side
    // ----------------------------------------
    wire logic [7:0] status_word = {5'h00, state == ST_STOP, state == ST_EXEC, READY_O};
    wire logic [7:0] rd_mux = (BUS_ADDR_I == ADDR_FLAGS) ? flags :
                              (BUS_ADDR_I == ADDR_PTR0) ? ptr0 :
                              (BUS_ADDR_I == ADDR_PTR1) ? ptr1 :
                              (BUS_ADDR_I == ADDR_STATUS) ? status_word : 8'h00;

    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            BUS_RDATA_O <= 8'h00;
        end
        else
        begin
            BUS_RDATA_O <= BUS_RD_I ? rd_mux : 8'h00;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_scf_carry: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        finish && is_scf |=> flags[FL_C] && flags[6:0] == $past(flags[6:0]))
        else $error("set carry wrong");

    a_shr_value: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        finish && is_shr |=> RESULT_O.value == {$past(cur.dst[7]), $past(cur.dst[7:1])})
        else $error("shift result wrong");

    a_shr_flags: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        finish && is_shr |=> flags[FL_C] == $past(cur.dst[0]) && !flags[FL_V]
            && flags[FL_H] == $past(flags[FL_H]))
        else $error("shift flags wrong");

    a_ptr_both: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        finish && is_ptr && cur.src[1:0] == 2'b00 |=> !ptr0[3] && ptr1[3]
            && ptr0[7:4] == ptr1[7:4])
        else $error("both pointers wrong");

    a_ptr_one: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        finish && is_ptr && cur.src[1:0] == 2'b01 |=> ptr1[7:3] == $past(cur.src[7:3])
            && ptr0 == $past(ptr0))
        else $error("pointer one wrong");

    a_sub_value: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        finish && (is_sub || is_sbc) |=> RESULT_O.write
            && RESULT_O.value == $past(cur.dst - cur.src - {7'h00, carry_in}))
        else $error("subtract result wrong");

    a_sub_borrow: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        finish && is_sub |=> flags[FL_C] == ($past(cur.src) > $past(cur.dst)) && flags[FL_D])
        else $error("subtract carry wrong");

    a_long_cycles: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        take && INSTR_I.opcode == OP_SBC_RIR |=> !finish [*5] ##1 finish)
        else $error("six cycle count wrong");

    a_short_cycles: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        take && INSTR_I.opcode == OP_SET_CARRY |=> !finish [*3] ##1 finish)
        else $error("four cycle count wrong");

    a_stop_hold: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        state == ST_STOP && !wake |=> state == ST_STOP
            && (ptr0 == $past(ptr0) || $past(BUS_WR_I)))
        else $error("stop not held");

    a_stop_wake: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        state == ST_STOP && wake |=> state == ST_IDLE ##1 !CLK_STOP_O)
        else $error("stop not left");

    a_sub_half: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        finish && (is_sub || is_sbc) |=> flags[FL_D]
            && flags[FL_H] == ({1'b0, $past(cur.dst[3:0])}
            < {1'b0, $past(cur.src[3:0])} + {4'h0, $past(carry_in)}))
        else $error("subtract half carry wrong");

    a_sub_ovf: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        finish && (is_sub || is_sbc) |=> flags[FL_V] ==
            ($past(cur.dst[7]) != $past(cur.src[7]) && RESULT_O.value[7] == $past(cur.src[7])))
        else $error("subtract overflow wrong");

    a_sub_zero_sign: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        finish && (is_sub || is_sbc) |=> flags[FL_Z] == (RESULT_O.value == 8'h00)
            && flags[FL_S] == RESULT_O.value[7])
        else $error("subtract zero or sign wrong");

    a_sbc_borrow: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        finish && is_sbc |=> flags[FL_D] && flags[FL_C] ==
            ({1'b0, $past(cur.src)} + {8'h00, $past(carry_in)} > {1'b0, $past(cur.dst)}))
        else $error("borrow carry wrong");

    a_sbc_cycles: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        take && INSTR_I.opcode == OP_SBC_BASE |=> !finish [*3] ##1 finish)
        else $error("borrow subtract cycle count wrong");

    a_stop_enter: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        finish && is_stop |=> CLK_STOP_O && !READY_O && flags == $past(flags))
        else $error("stop entry wrong");

    a_ptr_zero: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        finish && is_ptr && cur.src[1:0] == 2'b10 |=> ptr0[7:3] == $past(cur.src[7:3])
            && ptr0[2:0] == $past(ptr0[2:0]) && ptr1 == $past(ptr1))
        else $error("pointer zero wrong");

    a_shr_zero_sign: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        finish && is_shr |=> flags[FL_Z] == (RESULT_O.value == 8'h00)
            && flags[FL_S] == RESULT_O.value[7] && flags[FL_D] == $past(flags[FL_D]))
        else $error("shift zero or sign wrong");
endmodule // cxu_exec

// *** sim/cpu_subtract_shift_pointer_ops_bench.sv ***
// self-checking bench for the subtract, shift, pointer and stop unit
`timescale 1ns/1ps
module cpu_subtract_shift_pointer_ops_bench;
    import cxu_pkg::*;
    // ----------------------------------------
    // stimulus, design and model state
    // ----------------------------------------
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic instr_valid_i = 1'b0;
    cxu_instr_t instr_i = '0;
    logic ext_int_i = 1'b0;
    logic [7:0] bus_addr_i = 8'h00;
    logic [7:0] bus_wdata_i = 8'h00;
    logic bus_wr_i = 1'b0;
    logic bus_rd_i = 1'b0;
    logic [7:0] bus_rdata_o;
    logic ready_o;
    logic done_o;
    cxu_result_t result_o;
    logic [7:0] flags_o;
    logic clk_stop_o;
    logic [7:0] m_flags;
    logic [7:0] m_ptr0;
    logic [7:0] m_ptr1;
    int n_errors = 0;
    int checks_done = 0;
    always #12.5 clk_i = ~clk_i;
    cxu_exec u_dut (.CLK_I(clk_i), .SYS_RST_I(sys_rst_i), .INSTR_VALID_I(instr_valid_i),
        .INSTR_I(instr_i), .EXT_INT_I(ext_int_i), .BUS_ADDR_I(bus_addr_i),
        .BUS_WDATA_I(bus_wdata_i), .BUS_WR_I(bus_wr_i), .BUS_RD_I(bus_rd_i),
        .BUS_RDATA_O(bus_rdata_o), .READY_O(ready_o), .DONE_O(done_o),
        .RESULT_O(result_o), .FLAGS_O(flags_o), .CLK_STOP_O(clk_stop_o));
    // ----------------------------------------
    // shared tasks; all start and end right after a rising edge
    // ----------------------------------------
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic timed_out();
        n_errors++;
        $display("CHECK FAILED wait expected handshake seen timeout");
        stop_test();
    endtask
    // outputs read at an edge are the settled values of the cycle before it
    task automatic exec(input logic [7:0] op, input logic [7:0] d, input logic [7:0] s,
                        output int lat);
        int i;
        instr_i <= {op, d, s};
        instr_valid_i <= 1'b1;
        for (i = 0; i <= 30; i++)
        begin
            @(posedge clk_i);
            if (ready_o === 1'b1)
                break;
        end
        if (i > 30)
            timed_out();
        instr_valid_i <= 1'b0;
        for (lat = 1; lat <= 12; lat++)
        begin
            @(posedge clk_i);
            if (done_o === 1'b1)
                break;
        end
        if (lat > 12)
            timed_out();
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
        bus_addr_i <= a;
        bus_wdata_i <= v;
        bus_wr_i <= 1'b1;
        @(posedge clk_i);
        bus_wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp);
        bus_addr_i <= a;
        bus_rd_i <= 1'b1;
        @(posedge clk_i);
        bus_rd_i <= 1'b0;
        @(posedge clk_i);
        check("read data", {1'b0, bus_rdata_o}, {1'b0, exp});
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        int k;
        int lat;
        logic [7:0] op;
        logic [7:0] d;
        logic [7:0] s;
        logic [7:0] res;
        logic [8:0] diff;
        logic [4:0] hb;
        logic cin;
        void'($urandom(32'h6ae7));
        repeat (6) @(posedge clk_i);
        check("reset handshake", {7'h00, ready_o, done_o}, 9'h000);
        check("reset result", result_o, 9'h000);
        check("reset read data", {1'b0, bus_rdata_o}, 9'h000);
        check("reset flags", {clk_stop_o, flags_o}, {1'b0, RST_FLAGS});
        sys_rst_i <= 1'b0;
        m_flags = RST_FLAGS;
        m_ptr0 = RST_PTR0;
        m_ptr1 = RST_PTR1;
        @(posedge clk_i);
        bus_rd(ADDR_PTR0, m_ptr0);
        bus_rd(ADDR_PTR1, m_ptr1);
        bus_wr(8'h00, 8'hA5);
        bus_rd(8'h00, 8'h00);
        bus_wr(ADDR_STATUS, 8'hFF);
        bus_rd(ADDR_STATUS, 8'h01);
        // random operands; each borrow op takes the carry left by the subtract before it
        for (k = 0; k < 60; k++)
        begin
            op = ((k % 2) != 0 ? OP_SBC_BASE : OP_SUB_BASE) + 8'((k / 2) % 5);
            d = (k == 0) ? 8'h21 : 8'($urandom);
            s = (k == 0) ? 8'h90 : 8'($urandom);
            cin = op[4] ? m_flags[FL_C] : 1'b0;
            diff = {1'b0, d} - {1'b0, s} - {8'h00, cin};
            hb = {1'b0, d[3:0]} - {1'b0, s[3:0]} - {4'h0, cin};
            res = diff[7:0];
            m_flags[FL_C] = diff[8];
            m_flags[FL_Z] = (res == 8'h00);
            m_flags[FL_S] = res[7];
            m_flags[FL_V] = (d[7] != s[7]) && (res[7] == s[7]);
            m_flags[FL_D] = 1'b1;
            m_flags[FL_H] = hb[4];
            exec(op, d, s, lat);
            check("sub latency", 9'(lat), (op[3:0] == 4'h2) ? 9'd5 : 9'd7);
            check("sub result", result_o, {res, 1'b1});
            check("sub flags", {1'b0, flags_o}, {1'b0, m_flags});
        end
        for (k = 0; k < 8; k++)
        begin
            d = (k == 0) ? 8'h9A : 8'($urandom);
            res = {d[7], d[7:1]};
            m_flags[FL_C] = d[0];
            m_flags[FL_Z] = (res == 8'h00);
            m_flags[FL_S] = res[7];
            m_flags[FL_V] = 1'b0;
            exec(OP_SHR_DIR + 8'(k % 2), d, 8'h00, lat);
            check("shift latency", 9'(lat), 9'd5);
            check("shift result", result_o, {res, 1'b1});
            check("shift flags", {1'b0, flags_o}, {1'b0, m_flags});
        end
        // carry forced from both prior states; an unknown opcode must change nothing
        for (k = 0; k < 3; k++)
        begin
            m_flags = 8'($urandom) & 8'h7F;
            bus_wr(ADDR_FLAGS, m_flags);
            if (k == 1)
                m_flags[FL_C] = 1'b1;
            bus_wr(ADDR_FLAGS, m_flags);
            bus_rd(ADDR_FLAGS, m_flags);
            exec((k == 2) ? 8'h00 : OP_SET_CARRY, 8'h5A, 8'hA5, lat);
            if (k != 2)
                m_flags[FL_C] = 1'b1;
            check("set carry latency", 9'(lat), 9'd5);
            check("set carry write", {8'h00, result_o.write}, 9'h000);
            check("set carry flags", {1'b0, flags_o}, {1'b0, m_flags});
        end
        m_ptr0 = 8'($urandom);
        m_ptr1 = 8'($urandom);
        bus_wr(ADDR_PTR0, m_ptr0);
        bus_wr(ADDR_PTR1, m_ptr1);
        for (k = 0; k < 8; k++)
        begin
            s = {6'($urandom), 2'(k % 4)};
            if (s[1:0] == 2'b10)
                m_ptr0[7:3] = s[7:3];
            if (s[1:0] == 2'b01)
                m_ptr1[7:3] = s[7:3];
            if (s[1:0] == 2'b00)
            begin
                m_ptr0[7:3] = {s[7:4], 1'b0};
                m_ptr1[7:3] = {s[7:4], 1'b1};
            end
            exec(OP_LOAD_PTR, 8'h00, s, lat);
            check("pointer latency", 9'(lat), 9'd5);
            check("pointer flags", {1'b0, flags_o}, {1'b0, m_flags});
            bus_rd(ADDR_PTR0, m_ptr0);
            bus_rd(ADDR_PTR1, m_ptr1);
        end
        // ----------------------------------------
        // stop, refused work, wake by interrupt and by reset
        // ----------------------------------------
        for (k = 0; k < 2; k++)
        begin
            exec(OP_STOP, 8'h00, 8'h00, lat);
            check("stop latency", 9'(lat), 9'd5);
            repeat (2) @(posedge clk_i);
            check("stop level", {8'h00, clk_stop_o}, 9'h001);
            instr_i <= {OP_SUB_BASE, 8'h12, 8'h03};
            instr_valid_i <= 1'b1;
            repeat (6)
            begin
                @(posedge clk_i);
                check("stopped refuses", {7'h00, ready_o, done_o}, 9'h000);
            end
            instr_valid_i <= 1'b0;
            bus_rd(ADDR_FLAGS, m_flags);
            bus_rd(ADDR_PTR1, m_ptr1);
            bus_rd(ADDR_STATUS, 8'h04);
            if (k == 0)
                ext_int_i <= 1'b1;
            else
            begin
                sys_rst_i <= 1'b1;
                // reset held long, standing in for the oscillator settling time
                repeat (6) @(posedge clk_i);
                sys_rst_i <= 1'b0;
                m_flags = RST_FLAGS;
                m_ptr0 = RST_PTR0;
                m_ptr1 = RST_PTR1;
            end
            for (lat = 0; lat <= 10; lat++)
            begin
                @(posedge clk_i);
                if (ready_o === 1'b1)
                    break;
            end
            if (lat > 10)
                timed_out();
            check("woken", {8'h00, clk_stop_o}, 9'h000);
            ext_int_i <= 1'b0;
            @(posedge clk_i);
            bus_rd(ADDR_PTR0, m_ptr0);
            bus_rd(ADDR_PTR1, m_ptr1);
            bus_rd(ADDR_FLAGS, m_flags);
        end
        stop_test();
    end
endmodule // cpu_subtract_shift_pointer_ops_bench
